// file: logic/cld_instruction_decoder.sv
/*
  host instruction interpreter of a character display controller: decodes
  instructions, keeps the address counter, display offset, busy flag, text
  and glyph memories, and the status and data read path.
  assumes the host keeps select, read/write and data stable from the strobe
  rise until three core clocks after its fall.
*/
`default_nettype none

// Functional notes
// - clear fills text with spaces, counter zero
// - clear sets increment, cursor to home
// - home zeroes counter and offset, selects text memory
// - entry mode stores step direction flag
// - pan only on text write with pan set
// - display control latches on, cursor, blink
// - blink alternates cursor cell with all dots
// - shift moves cursor or whole display
// - display shift keeps counter, all lines together
// - two-line cursor wraps line one to two
// - function set picks 8-bit or nibble pairs
// - function set picks line count and font
// - glyph address set loads six bits
// - text address set loads seven bits
// - one-line text addresses run contiguous
// - two-line text addresses split in two
// - status read gives busy and counter
// - data write goes to selected memory
// - data access steps counter by direction
// - glyph access mirrors text access
// - busy lasts per instruction class
// - data read returns latch, first invalid
module cld_instruction_decoder #(
  parameter int CLEAR_CYCLES = cld_pkg::CLEAR_CYCLES,
  parameter int CMD_CYCLES = cld_pkg::CMD_CYCLES,
  parameter int DATA_CYCLES = cld_pkg::DATA_CYCLES,
  parameter int BLINK_HALF_CYCLES = cld_pkg::BLINK_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic register_select,
  input wire logic rw_select,
  input wire logic enable_strobe,
  input wire logic [7:0] host_bus_lines_in,
  output logic [7:0] host_bus_lines_out,
  output logic host_bus_lines_oe,
  output logic busy_indicator,
  output logic [6:0] address_counter,
  output logic [6:0] shift_offset,
  output logic glyph_target,
  output logic entry_increment,
  output logic auto_pan_enable,
  output logic display_on,
  output logic cursor_visible,
  output logic blink_enable,
  output logic bus_width_select,
  output logic two_line_mode,
  output logic large_font,
  input wire logic scan_line,
  input wire logic [6:0] scan_col,
  output logic [7:0] scan_char,
  output logic scan_cursor,
  output logic scan_all_dots,
  output logic scan_blank,
  input wire logic [5:0] glyph_rd_addr,
  output logic [7:0] glyph_rd_data
);

  localparam int BW = cld_pkg::BUSY_W;
  localparam int KW = cld_pkg::BLINK_W;
  localparam int NW = cld_pkg::NIB_W;
  localparam int GW = cld_pkg::GLYPH_AW;

  logic strobe_s;
  logic strobe_fall;
  logic sel_hold_reg;
  logic rw_hold_reg;
  logic [7:0] bus_hold_reg;
  logic nib_phase_reg;
  logic [NW-1:0] nib_hi_reg;
  logic exec;
  logic [7:0] cmd_byte;
  cld_pkg::cld_op_t op;
  logic acc_op;
  logic [BW-1:0] load_cnt;
  cld_pkg::cld_state_t state_reg;
  logic busy_reg;
  logic [BW-1:0] busy_cnt_reg;
  logic [6:0] fill_addr_reg;
  logic [6:0] address_counter_reg;
  logic [6:0] shift_offset_reg;
  logic glyph_target_reg;
  logic entry_inc_reg;
  logic auto_pan_reg;
  logic display_on_reg;
  logic cursor_on_reg;
  logic blink_on_reg;
  logic bus_8bit_reg;
  logic two_line_reg;
  logic large_font_reg;
  logic [7:0] text_ram [cld_pkg::TEXT_DEPTH];
  logic [7:0] glyph_ram [cld_pkg::GLYPH_DEPTH];
  logic reload_reg;
  logic [7:0] data_latch_reg;
  logic [7:0] status_word;
  logic [7:0] read_word;
  logic [7:0] bus_out_reg;
  logic bus_oe_reg;
  logic [KW-1:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic [6:0] span;
  logic [6:0] step_data;
  logic [6:0] scan_eff;
  logic [7:0] scan_sum;
  logic [6:0] scan_addr;
  logic [7:0] scan_char_reg;
  logic scan_cursor_reg;
  logic scan_all_dots_reg;
  logic scan_blank_reg;
  logic [7:0] glyph_rd_reg;

  cld_strobe_sync u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .strobe_in(enable_strobe),
    .strobe_level(strobe_s),
    .strobe_fall(strobe_fall)
  );

  // sample pins while the strobe is high, used at its fall
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sel_hold_reg <= 1'h0;
      rw_hold_reg <= 1'h0;
      bus_hold_reg <= 8'h00;
    end else if (strobe_s) begin
      sel_hold_reg <= register_select;
      rw_hold_reg <= rw_select;
      bus_hold_reg <= host_bus_lines_in;
    end
  end

  // nibble pairing: high nibble first on the upper lines
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      nib_phase_reg <= 1'h0;
      nib_hi_reg <= 4'h0;
    end else if (strobe_fall) begin
      if (bus_8bit_reg || nib_phase_reg) begin
        nib_phase_reg <= 1'h0;
      end else begin
        nib_phase_reg <= 1'h1;
        nib_hi_reg <= bus_hold_reg[7:NW];
      end
    end
  end

  assign exec = strobe_fall && (bus_8bit_reg || nib_phase_reg);
  assign cmd_byte = bus_8bit_reg ? bus_hold_reg : {nib_hi_reg, bus_hold_reg[7:NW]};
  assign op = cld_pkg::cld_decode(sel_hold_reg, rw_hold_reg, cmd_byte);
  // instructions offered while busy are dropped; status reads always pass
  assign acc_op = exec && !busy_reg && op != cld_pkg::CLD_OP_STATUS
                  && op != cld_pkg::CLD_OP_NONE;
  assign span = two_line_reg ? cld_pkg::TWO_LINE_SPAN : cld_pkg::ONE_LINE_SPAN;
  assign step_data = cld_pkg::cld_step_addr(address_counter_reg, entry_inc_reg,
                                            two_line_reg, glyph_target_reg);

  // busy time per instruction class
  always_comb begin
    load_cnt = BW'(CMD_CYCLES - 1);
    if (op == cld_pkg::CLD_OP_CLEAR || op == cld_pkg::CLD_OP_HOME) begin
      load_cnt = BW'(CLEAR_CYCLES - 1);
    end else if (op == cld_pkg::CLD_OP_DATA_WR || op == cld_pkg::CLD_OP_DATA_RD) begin
      load_cnt = BW'(DATA_CYCLES - 1);
    end
  end

  // busy flag and clear fill sequence
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= cld_pkg::CLD_IDLE;
      busy_reg <= 1'h0;
      busy_cnt_reg <= {BW{1'h0}};
      fill_addr_reg <= cld_pkg::ADDR_ZERO;
    end else if (acc_op) begin
      busy_reg <= 1'h1;
      busy_cnt_reg <= load_cnt;
      fill_addr_reg <= cld_pkg::ADDR_ZERO;
      state_reg <= (op == cld_pkg::CLD_OP_CLEAR) ? cld_pkg::CLD_FILL : cld_pkg::CLD_EXEC;
    end else begin
      case (state_reg)
        cld_pkg::CLD_FILL: begin
          if (busy_cnt_reg != {BW{1'h0}}) busy_cnt_reg <= busy_cnt_reg - BW'(1);
          fill_addr_reg <= fill_addr_reg + cld_pkg::ADDR_ONE;
          if (fill_addr_reg == cld_pkg::TEXT_LAST) state_reg <= cld_pkg::CLD_EXEC;
        end
        cld_pkg::CLD_EXEC: begin
          if (busy_cnt_reg == {BW{1'h0}}) begin
            state_reg <= cld_pkg::CLD_IDLE;
            busy_reg <= 1'h0;
          end else begin
            busy_cnt_reg <= busy_cnt_reg - BW'(1);
          end
        end
        default: busy_reg <= 1'h0;
      endcase
    end
  end

  // address counter and memory target
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      address_counter_reg <= cld_pkg::ADDR_ZERO;
      glyph_target_reg <= 1'h0;
    end else if (acc_op) begin
      case (op)
        cld_pkg::CLD_OP_CLEAR, cld_pkg::CLD_OP_HOME: begin
          address_counter_reg <= cld_pkg::ADDR_ZERO;
          glyph_target_reg <= 1'h0;
        end
        cld_pkg::CLD_OP_SHIFT: begin
          if (!cmd_byte[cld_pkg::F_SHIFT_DISPLAY]) begin
            address_counter_reg <= cld_pkg::cld_step_addr(address_counter_reg,
              cmd_byte[cld_pkg::F_SHIFT_RIGHT], two_line_reg, glyph_target_reg);
          end
        end
        cld_pkg::CLD_OP_GLYPH_ADDR: begin
          address_counter_reg <= {1'h0, cmd_byte[GW-1:0]};
          glyph_target_reg <= 1'h1;
        end
        cld_pkg::CLD_OP_TEXT_ADDR: begin
          address_counter_reg <= cmd_byte[6:0];
          glyph_target_reg <= 1'h0;
        end
        cld_pkg::CLD_OP_DATA_WR, cld_pkg::CLD_OP_DATA_RD: begin
          address_counter_reg <= step_data;
        end
        default: address_counter_reg <= address_counter_reg;
      endcase
    end
  end

  // mode flags from entry, display and function set
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      entry_inc_reg <= cld_pkg::RST_ENTRY_INC;
      auto_pan_reg <= 1'h0;
      display_on_reg <= 1'h0;
      cursor_on_reg <= 1'h0;
      blink_on_reg <= 1'h0;
      bus_8bit_reg <= cld_pkg::RST_BUS_8BIT;
      two_line_reg <= 1'h0;
      large_font_reg <= 1'h0;
    end else if (acc_op) begin
      if (op == cld_pkg::CLD_OP_CLEAR) entry_inc_reg <= 1'h1;
      if (op == cld_pkg::CLD_OP_ENTRY) begin
        entry_inc_reg <= cmd_byte[cld_pkg::F_ENTRY_INC];
        auto_pan_reg <= cmd_byte[cld_pkg::F_ENTRY_PAN];
      end
      if (op == cld_pkg::CLD_OP_DISP) begin
        display_on_reg <= cmd_byte[cld_pkg::F_DISP_ON];
        cursor_on_reg <= cmd_byte[cld_pkg::F_DISP_CURSOR];
        blink_on_reg <= cmd_byte[cld_pkg::F_DISP_BLINK];
      end
      if (op == cld_pkg::CLD_OP_FUNC) begin
        bus_8bit_reg <= cmd_byte[cld_pkg::F_FUNC_WIDTH];
        two_line_reg <= cmd_byte[cld_pkg::F_FUNC_LINES];
        large_font_reg <= cmd_byte[cld_pkg::F_FUNC_FONT];
      end
    end
  end

  // display offset: shift instruction, auto pan, reset by clear and home
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      shift_offset_reg <= cld_pkg::ADDR_ZERO;
    end else if (acc_op) begin
      if (op == cld_pkg::CLD_OP_CLEAR || op == cld_pkg::CLD_OP_HOME) begin
        shift_offset_reg <= cld_pkg::ADDR_ZERO;
      end else if (op == cld_pkg::CLD_OP_SHIFT && cmd_byte[cld_pkg::F_SHIFT_DISPLAY]) begin
        shift_offset_reg <= cld_pkg::cld_step_offset(shift_offset_reg,
          !cmd_byte[cld_pkg::F_SHIFT_RIGHT], span);
      end else if (op == cld_pkg::CLD_OP_DATA_WR && auto_pan_reg && !glyph_target_reg) begin
        shift_offset_reg <= cld_pkg::cld_step_offset(shift_offset_reg,
          entry_inc_reg, span);
      end
    end
  end

  // memories: space fill during clear, data writes to the chosen memory
  always_ff @(posedge core_clk) begin
    if (state_reg == cld_pkg::CLD_FILL) begin
      text_ram[fill_addr_reg] <= cld_pkg::SPACE_CODE;
    end else if (acc_op && op == cld_pkg::CLD_OP_DATA_WR && !glyph_target_reg) begin
      text_ram[address_counter_reg] <= cmd_byte;
    end
    if (acc_op && op == cld_pkg::CLD_OP_DATA_WR && glyph_target_reg) begin
      glyph_ram[address_counter_reg[GW-1:0]] <= cmd_byte;
    end
  end

  // read latch refills after address set, cursor shift and data read
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reload_reg <= 1'h0;
      data_latch_reg <= 8'h00;
    end else begin
      reload_reg <= acc_op && (op == cld_pkg::CLD_OP_TEXT_ADDR
        || op == cld_pkg::CLD_OP_GLYPH_ADDR || op == cld_pkg::CLD_OP_DATA_RD
        || (op == cld_pkg::CLD_OP_SHIFT && !cmd_byte[cld_pkg::F_SHIFT_DISPLAY]));
      if (reload_reg) begin
        data_latch_reg <= glyph_target_reg ? glyph_ram[address_counter_reg[GW-1:0]]
                                           : text_ram[address_counter_reg];
      end
    end
  end

  assign status_word = {busy_reg, address_counter_reg};
  assign read_word = register_select ? data_latch_reg : status_word;

  // read data driven while the strobe is high
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bus_out_reg <= 8'h00;
      bus_oe_reg <= 1'h0;
    end else begin
      bus_oe_reg <= strobe_s && rw_select;
      bus_out_reg <= (bus_8bit_reg || !nib_phase_reg) ? read_word
                                                      : {read_word[NW-1:0], 4'h0};
    end
  end

  // blink phase generator
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      blink_cnt_reg <= {KW{1'h0}};
      blink_phase_reg <= 1'h0;
    end else if (blink_cnt_reg >= KW'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt_reg <= {KW{1'h0}};
      blink_phase_reg <= !blink_phase_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + KW'(1);
    end
  end

  // panel scan: every line moved by the same offset
  always_comb begin
    scan_sum = {1'h0, scan_col} + {1'h0, shift_offset_reg};
    if (scan_sum >= {1'h0, span}) scan_sum = scan_sum - {1'h0, span};
    scan_eff = scan_sum[6:0];
    scan_addr = (two_line_reg && scan_line) ? cld_pkg::LINE2_FIRST + scan_eff : scan_eff;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      scan_char_reg <= 8'h00;
      scan_cursor_reg <= 1'h0;
      scan_all_dots_reg <= 1'h0;
      scan_blank_reg <= 1'h1;
      glyph_rd_reg <= 8'h00;
    end else begin
      scan_char_reg <= text_ram[scan_addr];
      scan_cursor_reg <= cursor_on_reg && scan_addr == address_counter_reg;
      scan_all_dots_reg <= blink_on_reg && blink_phase_reg
                           && scan_addr == address_counter_reg;
      scan_blank_reg <= !display_on_reg;
      glyph_rd_reg <= glyph_ram[glyph_rd_addr];
    end
  end

  assign host_bus_lines_out = bus_out_reg;
  assign host_bus_lines_oe = bus_oe_reg;
  assign busy_indicator = busy_reg;
  assign address_counter = address_counter_reg;
  assign shift_offset = shift_offset_reg;
  assign glyph_target = glyph_target_reg;
  assign entry_increment = entry_inc_reg;
  assign auto_pan_enable = auto_pan_reg;
  assign display_on = display_on_reg;
  assign cursor_visible = cursor_on_reg;
  assign blink_enable = blink_on_reg;
  assign bus_width_select = bus_8bit_reg;
  assign two_line_mode = two_line_reg;
  assign large_font = large_font_reg;
  assign scan_char = scan_char_reg;
  assign scan_cursor = scan_cursor_reg;
  assign scan_all_dots = scan_all_dots_reg;
  assign scan_blank = scan_blank_reg;
  assign glyph_rd_data = glyph_rd_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic clear_acc;
  logic home_acc;
  logic dshift_acc;
  logic data_acc;
  assign clear_acc = acc_op && op == cld_pkg::CLD_OP_CLEAR;
  assign home_acc = acc_op && op == cld_pkg::CLD_OP_HOME;
  assign dshift_acc = acc_op && op == cld_pkg::CLD_OP_SHIFT
                      && cmd_byte[cld_pkg::F_SHIFT_DISPLAY];
  assign data_acc = acc_op && (op == cld_pkg::CLD_OP_DATA_WR || op == cld_pkg::CLD_OP_DATA_RD);

  chk_clear_home: assert property (clear_acc |=> entry_inc_reg
    && address_counter_reg == cld_pkg::ADDR_ZERO && shift_offset_reg == cld_pkg::ADDR_ZERO)
    else $error("clear did not home the counter");
  chk_clear_fill: assert property (clear_acc |=> state_reg == cld_pkg::CLD_FILL
    && fill_addr_reg == cld_pkg::ADDR_ZERO)
    else $error("clear did not start the space fill");
  chk_home_offset: assert property (home_acc |=> shift_offset_reg == cld_pkg::ADDR_ZERO
    && address_counter_reg == cld_pkg::ADDR_ZERO)
    else $error("return home left counter or offset");
  chk_entry_flag: assert property (acc_op && op == cld_pkg::CLD_OP_ENTRY
    |=> entry_inc_reg == $past(cmd_byte[cld_pkg::F_ENTRY_INC]))
    else $error("entry direction not stored");
  chk_dshift_keep: assert property (dshift_acc
    |=> address_counter_reg == $past(address_counter_reg))
    else $error("display shift moved the counter");
  chk_data_step: assert property (data_acc |=> address_counter_reg == $past(step_data))
    else $error("data access stepped the counter wrongly");
  chk_busy_set: assert property (acc_op |=> busy_reg ##0 state_reg != cld_pkg::CLD_IDLE)
    else $error("busy flag not raised on accept");
  chk_busy_release: assert property ($fell(busy_reg)
    |-> $past(busy_cnt_reg) == {BW{1'h0}})
    else $error("busy flag dropped before its time");
  chk_status_word: assert property (strobe_s && !register_select && rw_select
    && bus_8bit_reg |=> host_bus_lines_out == $past(status_word) && host_bus_lines_oe)
    else $error("status read does not show busy and counter");
  chk_blank_off: assert property (!display_on_reg [*2] |-> scan_blank_reg)
    else $error("panel not blanked with display off");

  cov_clear: cover property (clear_acc ##1 busy_reg [*3]);
  cov_nibble_pair: cover property (!bus_8bit_reg && strobe_fall ##[1:40] exec);
  cov_display_shift: cover property (dshift_acc);
  cov_data_read: cover property (acc_op && op == cld_pkg::CLD_OP_DATA_RD);

endmodule

`default_nettype wire

// file: logic/cld_pkg.sv
/*
  constants, types and address helpers used by the character display
  instruction decoder; its strobe synchroniser does not use them.
  assumes a 100 mhz core clock and a 7-bit display address space.
*/
`default_nettype none

package cld_pkg;

  localparam int CLK_MHZ = 100;
  localparam int CLEAR_TIME_NS = 1530000;
  localparam int CMD_TIME_NS = 39000;
  localparam int DATA_TIME_NS = 43000;
  localparam int BLINK_HALF_US = 400000;
  localparam int CLEAR_CYCLES = (CLEAR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CMD_CYCLES = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int DATA_CYCLES = (DATA_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_US * CLK_MHZ;
  localparam int BUSY_W = 18;
  localparam int BLINK_W = 26;

  localparam int TEXT_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam int GLYPH_AW = 6;
  localparam int NIB_W = 4;

  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] ADDR_ZERO = 7'h00;
  localparam logic [6:0] ADDR_ONE = 7'h01;
  localparam logic [6:0] TEXT_LAST = 7'h7f;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_SPAN = 7'h50;
  localparam logic [6:0] TWO_LINE_SPAN = 7'h28;
  localparam logic [5:0] GLYPH_ONE = 6'h01;

  // instruction opcode bits, highest set bit wins
  localparam int B_CLEAR = 0;
  localparam int B_HOME = 1;
  localparam int B_ENTRY = 2;
  localparam int B_DISP = 3;
  localparam int B_SHIFT = 4;
  localparam int B_FUNC = 5;
  localparam int B_GLYPH = 6;
  localparam int B_TEXT = 7;
  // argument fields
  localparam int F_ENTRY_INC = 1;
  localparam int F_ENTRY_PAN = 0;
  localparam int F_DISP_ON = 2;
  localparam int F_DISP_CURSOR = 1;
  localparam int F_DISP_BLINK = 0;
  localparam int F_SHIFT_DISPLAY = 3;
  localparam int F_SHIFT_RIGHT = 2;
  localparam int F_FUNC_WIDTH = 4;
  localparam int F_FUNC_LINES = 3;
  localparam int F_FUNC_FONT = 2;
  localparam int F_BUSY = 7;

  // reset values of the mode flags
  localparam logic RST_ENTRY_INC = 1'h1;
  localparam logic RST_BUS_8BIT = 1'h1;

  typedef enum logic [1:0] {CLD_IDLE, CLD_FILL, CLD_EXEC} cld_state_t;

  typedef enum logic [3:0] {
    CLD_OP_NONE, CLD_OP_STATUS, CLD_OP_DATA_WR, CLD_OP_DATA_RD,
    CLD_OP_CLEAR, CLD_OP_HOME, CLD_OP_ENTRY, CLD_OP_DISP,
    CLD_OP_SHIFT, CLD_OP_FUNC, CLD_OP_GLYPH_ADDR, CLD_OP_TEXT_ADDR
  } cld_op_t;

  function automatic cld_op_t cld_decode(input logic sel, input logic rd, input logic [7:0] b);
    cld_op_t op;
    op = CLD_OP_NONE;
    if (sel) op = rd ? CLD_OP_DATA_RD : CLD_OP_DATA_WR;
    else if (rd) op = CLD_OP_STATUS;
    else if (b[B_TEXT]) op = CLD_OP_TEXT_ADDR;
    else if (b[B_GLYPH]) op = CLD_OP_GLYPH_ADDR;
    else if (b[B_FUNC]) op = CLD_OP_FUNC;
    else if (b[B_SHIFT]) op = CLD_OP_SHIFT;
    else if (b[B_DISP]) op = CLD_OP_DISP;
    else if (b[B_ENTRY]) op = CLD_OP_ENTRY;
    else if (b[B_HOME]) op = CLD_OP_HOME;
    else if (b[B_CLEAR]) op = CLD_OP_CLEAR;
    return op;
  endfunction

  // one step of the address counter, with line wrap in two-line mode
  function automatic logic [6:0] cld_step_addr(input logic [6:0] a, input logic up,
                                               input logic two, input logic glyph);
    logic [6:0] r;
    r = up ? a + ADDR_ONE : a - ADDR_ONE;
    if (glyph) r = {1'h0, up ? a[GLYPH_AW-1:0] + GLYPH_ONE : a[GLYPH_AW-1:0] - GLYPH_ONE};
    else if (two) begin
      if (up && a == LINE1_LAST) r = LINE2_FIRST;
      else if (up && a == LINE2_LAST) r = ADDR_ZERO;
      else if (!up && a == LINE2_FIRST) r = LINE1_LAST;
      else if (!up && a == ADDR_ZERO) r = LINE2_LAST;
    end else begin
      if (up && a == ONE_LINE_LAST) r = ADDR_ZERO;
      else if (!up && a == ADDR_ZERO) r = ONE_LINE_LAST;
    end
    return r;
  endfunction

  // display offset step, modulo the line span
  function automatic logic [6:0] cld_step_offset(input logic [6:0] off, input logic up,
                                                 input logic [6:0] span);
    logic [6:0] r;
    if (up) r = (off >= span - ADDR_ONE) ? ADDR_ZERO : off + ADDR_ONE;
    else r = (off == ADDR_ZERO) ? span - ADDR_ONE : off - ADDR_ONE;
    return r;
  endfunction

endpackage

`default_nettype wire

// file: logic/cld_strobe_sync.sv
/*
  two-flop synchroniser for the host enable strobe with falling edge pulse.
  assumes the strobe is asynchronous to core_clk and held high or low for
  at least three core clock cycles.
*/
`default_nettype none

module cld_strobe_sync (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic strobe_in,
  output logic strobe_level,
  output logic strobe_fall
);

  logic meta_reg;
  logic level_reg;
  logic last_reg;

  // synchronise the host strobe before use
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      meta_reg <= 1'h0;
      level_reg <= 1'h0;
      last_reg <= 1'h0;
    end else begin
      meta_reg <= strobe_in;
      level_reg <= meta_reg;
      last_reg <= level_reg;
    end
  end

  assign strobe_level = level_reg;
  assign strobe_fall = last_reg && !level_reg;

endmodule

`default_nettype wire

// file: tb/cld_host_model.sv
/*
  host processor model on the decoder's parallel bus.
  assumes the core clock of the decoder; bytes go whole or as two nibbles.
*/
`default_nettype none
module cld_host_model (
  input wire logic core_clk,
  input wire logic [7:0] host_bus_lines_out,
  output logic register_select,
  output logic rw_select,
  output logic enable_strobe,
  output logic [7:0] host_bus_lines_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q;
  logic nib4;
  initial begin
    nib4 = 1'h0;
    register_select = 1'h0;
    rw_select = 1'h0;
    enable_strobe = 1'h0;
    host_bus_lines_in = 8'h00;
  end
  // one strobe, pins held well past the fall
  task automatic beat(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] r);
    @(posedge core_clk);
    register_select <= rs;
    rw_select <= rw;
    host_bus_lines_in <= d;
    enable_strobe <= 1'h1;
    repeat (6) @(posedge core_clk);
    r = host_bus_lines_out;
    enable_strobe <= 1'h0;
    repeat (5) @(posedge core_clk);
    host_bus_lines_in <= ~d;
  endtask
  // whole byte, or high then low nibble on the upper lines
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] r);
    logic [7:0] h;
    if (nib4) begin
      beat(rs, rw, {d[7:4], 4'h0}, h);
      beat(rs, rw, {d[3:0], 4'h0}, r);
      r = {h[7:4], r[7:4]};
    end else begin
      beat(rs, rw, d, r);
    end
  endtask
  // poll busy, then a margin before the next strobe
  task automatic ready();
    q = 8'hff;
    while (q[7] !== 1'h0) begin
      xfer(1'h0, 1'h1, 8'h00, q);
    end
    repeat (2) @(posedge core_clk);
  endtask
  task automatic cmd(input logic rs, input logic [7:0] d);
    ready();
    xfer(rs, 1'h0, d, q);
  endtask
  // one read, status or data, once busy clears
  task automatic get(input logic rs, output logic [7:0] r);
    ready();
    xfer(rs, 1'h1, 8'h00, r);
  endtask
endmodule
`default_nettype wire

// file: tb/test_char_lcd_instruction_decoder.sv
/*
  self-checking bench for the instruction decoder with a host model.
  assumes shortened busy and blink counts; the bus turns to nibbles near the end.
*/
`default_nettype none
module test_char_lcd_instruction_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic register_select, rw_select, enable_strobe, busy_indicator, entry_increment;
  logic display_on, cursor_visible, blink_enable, two_line_mode, bus_width_select;
  logic large_font, glyph_target, auto_pan_enable, scan_cursor, scan_all_dots, scan_blank;
  logic [7:0] host_bus_lines_in, host_bus_lines_out, q, n_dots, scan_char, glyph_rd_data;
  logic scan_line = 1'h0;
  logic [6:0] scan_col = 7'h00;
  logic [5:0] glyph_rd_addr = 6'h00;
  logic [6:0] address_counter, shift_offset;
  int n_errors = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  cld_instruction_decoder #(.CLEAR_CYCLES(200), .CMD_CYCLES(10), .DATA_CYCLES(12),
    .BLINK_HALF_CYCLES(16)) i_dut (.core_clk, .resetn, .register_select, .rw_select,
    .enable_strobe, .host_bus_lines_in, .host_bus_lines_out, .host_bus_lines_oe(),
    .busy_indicator, .address_counter, .shift_offset, .glyph_target, .entry_increment,
    .auto_pan_enable, .display_on, .cursor_visible, .blink_enable, .bus_width_select,
    .two_line_mode, .large_font, .scan_line, .scan_col, .scan_char,
    .scan_cursor, .scan_all_dots, .scan_blank, .glyph_rd_addr, .glyph_rd_data);
  cld_host_model i_host (.core_clk, .host_bus_lines_out, .register_select, .rw_select,
    .enable_strobe, .host_bus_lines_in);
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // bit 8 is the select line
  task automatic c(input logic [8:0] v);
    i_host.cmd(v[8], v[7:0]);
  endtask
  task automatic st(input logic [7:0] exp);
    i_host.get(1'h0, q);
    check("status", q, exp);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'h1;
    c(9'h001);
    check("busy", {7'h00, busy_indicator}, 8'h01);
    st(8'h00);
    check("increment", {7'h00, entry_increment}, 8'h01);
    c(9'h038);
    check("lines", {6'h00, two_line_mode, bus_width_select}, 8'h03);
    c(9'h0c0);
    c(9'h004);
    c(9'h141);
    st(8'h27);
    c(9'h006);
    c(9'h142);
    st(8'h40);
    c(9'h0a7);
    i_host.get(1'h1, q);
    check("read", q, 8'h42);
    c(9'h01c);
    check("offset", {1'h0, shift_offset}, 8'h27);
    st(8'h40);
    c(9'h010);
    st(8'h27);
    c(9'h002);
    st(8'h00);
    check("home offset", {1'h0, shift_offset}, 8'h00);
    c(9'h00f);
    check("control", {5'h00, display_on, cursor_visible, blink_enable}, 8'h07);
    c(9'h045);
    c(9'h007);
    c(9'h11f);
    st(8'h06);
    check("glyph pan", {1'h0, shift_offset}, 8'h00);
    check("target", {6'h00, glyph_target, auto_pan_enable}, 8'h03);
    c(9'h080);
    c(9'h130);
    check("text pan", {1'h0, shift_offset}, 8'h01);
    scan_line <= 1'h1;
    scan_col <= 7'h27;
    glyph_rd_addr <= 6'h05;
    repeat (2) @(posedge core_clk);
    check("scan wrap", scan_char, 8'h41);
    check("glyph read", glyph_rd_data, 8'h1f);
    scan_line <= 1'h0;
    scan_col <= 7'h00;
    n_dots = 8'h00;
    repeat (2) @(posedge core_clk);
    check("cursor char", scan_char, 8'h20);
    check("cursor", {6'h00, scan_cursor, scan_blank}, 8'h02);
    repeat (32) begin
      @(posedge core_clk);
      n_dots = n_dots + {7'h00, scan_all_dots};
    end
    check("blink", n_dots, 8'h10);
    c(9'h02c);
    i_host.nib4 = 1'h1;
    check("width", {6'h00, large_font, bus_width_select}, 8'h02);
    c(9'h080);
    i_host.get(1'h1, q);
    check("nibble read", q, 8'h30);
    st(8'h01);
    check("read pan", {1'h0, shift_offset}, 8'h01);
    results();
  end
  initial begin
    #200000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
